// File: hw/css_serial.sv
module css_serial #(
  parameter int HALF_BASE = css_pkg::HALF_BASE
) (
  // system
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // serial pins
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_n,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // status
  output logic             serial_buffer_irq
);
  // the data input passes three sync stages, so a shorter half period
  // would sample it before the far side's new bit has arrived
  initial
  begin
    if (HALF_BASE < 4)
      $error("HALF_BASE must be at least four");
    if (HALF_BASE > 1023)
      $error("HALF_BASE overflows the divider at the slowest rate");
    if (css_pkg::BITS_PER_BYTE != 8)
      $error("only eight-bit bytes are served");
  end

  css_pkg::css_ctrl_t ctrl_r;
  logic [7:0]  buf_r, shift_r;
  logic [3:0]  bitcnt_r;
  logic        active_r, shifting_r, buf_full_r, buf_empty_r, stop_req_r;
  logic        drop_r, sck_r, sck_phase_r, ack_r;
  logic [2:0]  sync_sck_r, sync_si_r;
  logic [15:0] div_r;
  logic        ext_clk, wr_ctrl, wr_data, rd_data, acc, commit;
  logic        shift_go, load_ev, fill_ev;
  logic        fall_ev, rise_ev, int_tick;
  logic [15:0] half_len;

  function automatic logic [15:0] half_of(input logic [2:0] sel);
    half_of = 16'(HALF_BASE) << sel;
  endfunction

  function automatic logic sends(input css_pkg::css_mode_t m);
    sends = (m == css_pkg::MODE_TX) || (m == css_pkg::MODE_TXRX);
  endfunction

  function automatic logic hears(input css_pkg::css_mode_t m);
    hears = (m == css_pkg::MODE_RX) || (m == css_pkg::MODE_TXRX);
  endfunction

  assign ext_clk  = (ctrl_r.clk_sel == css_pkg::CLK_EXTERNAL);
  assign acc      = (avs_read | avs_write) & ~ack_r;
  // side effects land only at the edge where the master sees waitrequest low
  assign commit   = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ctrl  = commit & avs_write & (avs_address == css_pkg::CTRL_IDX);
  assign wr_data  = commit & avs_write & (avs_address == css_pkg::DATA_IDX);
  assign rd_data  = commit & avs_read & (avs_address == css_pkg::DATA_IDX);
  assign half_len = half_of(ctrl_r.clk_sel);

  // bus: one wait cycle, answer on the second edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ack_r <= 1'b0;
    else
      ack_r <= acc;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~acc;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h0000_0000;
    else if (acc && avs_read)
    begin
      unique case (avs_address)
        css_pkg::CTRL_IDX: avs_readdata <= {25'h0000000, ctrl_r};
        css_pkg::DATA_IDX: avs_readdata <= {24'h000000, buf_r};
        css_pkg::STAT_IDX: avs_readdata <= {28'h0000000, active_r, shifting_r,
                                            buf_full_r, buf_empty_r};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_sck_r <= 3'h7;
      sync_si_r  <= 3'h7;
    end
    else
    begin
      sync_sck_r <= {sync_sck_r[1:0], serial_clock_pin_in};
      sync_si_r  <= {sync_si_r[1:0], serial_in_pin};
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_r <= css_pkg::CTRL_RESET[6:0];
    else if (wr_ctrl)
      ctrl_r <= avs_writedata[6:0];
    else if (ctrl_r.abort)
      ctrl_r.abort <= 1'b0;
  end

  // internal clock divider; runs only while a byte is shifting
  assign int_tick = !ext_clk && shifting_r && (div_r == half_len - 16'h0001);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_r <= 16'h0000;
    else if (!shifting_r || ext_clk || int_tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001;
  end

  // the external clock is only seen through the sync, so each phase must last
  always_comb
  begin
    if (ext_clk)
    begin
      fall_ev = sync_sck_r[2] & ~sync_sck_r[1];
      rise_ev = ~sync_sck_r[2] & sync_sck_r[1];
    end
    else
    begin
      fall_ev = int_tick & sck_r;
      rise_ev = int_tick & ~sck_r;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sck_r <= 1'b1;
    else if (!shifting_r || ext_clk)
      sck_r <= 1'b1;
    else if (int_tick)
      sck_r <= ~sck_r;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_clock_pin_out  <= 1'b1;
      serial_clock_pin_oe_n <= 1'b1;
    end
    else
    begin
      // same next value as sck_r, so the pin and the data edge line up
      if (!shifting_r || ext_clk)
        serial_clock_pin_out <= 1'b1;
      else if (int_tick)
        serial_clock_pin_out <= ~sck_r;
      else
        serial_clock_pin_out <= sck_r;
      serial_clock_pin_oe_n <= ext_clk;
    end
  end

  // transfer engine
  logic tx_en, rx_en, can_start, mode_chg;
  assign tx_en    = sends(ctrl_r.mode);
  assign rx_en    = hears(ctrl_r.mode);
  assign mode_chg = wr_ctrl && (avs_writedata[css_pkg::MODE_LSB +: 2] != ctrl_r.mode);
  // with the internal clock, next byte only once the buffer is serviced
  always_comb
  begin
    unique case (ctrl_r.mode)
      css_pkg::MODE_TX:   can_start = !buf_empty_r;
      css_pkg::MODE_RX:   can_start = !buf_full_r;
      css_pkg::MODE_TXRX: can_start = !buf_full_r && !buf_empty_r;
      default:            can_start = 1'b0;
    endcase
  end

  // byte start, load and completion events, mirrored from the engine below
  assign shift_go = !ctrl_r.abort && active_r && !shifting_r && ctrl_r.start
                    && !stop_req_r && (ext_clk || can_start);
  assign load_ev  = shift_go && tx_en;
  assign fill_ev  = !ctrl_r.abort && active_r && shifting_r && rise_ev && rx_en
                    && !drop_r && (bitcnt_r == 4'(css_pkg::BITS_PER_BYTE - 1));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      drop_r <= 1'b0;
    else if (shift_go)
      drop_r <= rx_en && buf_full_r;
  end

  // in txrx only the full buffer requests service, after the read and write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      serial_buffer_irq <= 1'b0;
    else
      serial_buffer_irq <= (load_ev && !rx_en) || fill_ev;
  end

  // the last bit of the previous byte stands until the first falling edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      serial_out_pin <= 1'b1;
    else if (!ctrl_r.abort && active_r && shifting_r && fall_ev && tx_en)
      serial_out_pin <= shift_r[0];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active_r    <= 1'b0;
      shifting_r  <= 1'b0;
      stop_req_r  <= 1'b0;
      bitcnt_r    <= 4'h0;
      shift_r     <= 8'h00;
      buf_r       <= 8'h00;
      buf_empty_r <= 1'b1;
      buf_full_r  <= 1'b0;
    end
    else
    begin
      if (wr_data)
      begin
        buf_r       <= avs_writedata[7:0];
        buf_empty_r <= 1'b0;
      end
      if (rd_data)
        buf_full_r <= 1'b0;
      if (ctrl_r.abort)
      begin
        active_r   <= 1'b0;
        shifting_r <= 1'b0;
        stop_req_r <= 1'b0;
        bitcnt_r   <= 4'h0;
      end
      else if (mode_chg && !active_r)
      begin
        buf_r       <= 8'h00;
        buf_empty_r <= 1'b1;
        buf_full_r  <= 1'b0;
      end
      else if (!active_r)
      begin
        if (ctrl_r.start && (!tx_en || !buf_empty_r))
          active_r <= 1'b1;
        stop_req_r <= 1'b0;
      end
      else
      begin
        if (!ctrl_r.start)
          stop_req_r <= 1'b1;
        if (!shifting_r)
        begin
          if (stop_req_r || !ctrl_r.start)
            active_r <= 1'b0;
          else if (ext_clk || can_start)
          begin
            shifting_r <= 1'b1;
            bitcnt_r   <= 4'h0;
            if (tx_en)
            begin
              // empty buffer under external clock resends old data as dummy
              shift_r     <= buf_r;
              buf_empty_r <= 1'b1;
            end
          end
        end
        else
        begin
          if (rise_ev)
          begin
            shift_r  <= {(rx_en ? sync_si_r[2] : shift_r[0]), shift_r[7:1]};
            bitcnt_r <= bitcnt_r + 4'h1;
            if (bitcnt_r == 4'(css_pkg::BITS_PER_BYTE - 1))
            begin
              shifting_r <= 1'b0;
              if (rx_en && !drop_r)
              begin
                buf_r      <= {sync_si_r[2], shift_r[7:1]};
                buf_full_r <= 1'b1;
              end
            end
          end
        end
      end
    end
  end
endmodule

// File: hw/css_pkg.sv
package css_pkg;
  // register word addresses (byte address = index * 4)
  localparam logic [3:0] CTRL_IDX   = 4'h0;
  localparam logic [3:0] DATA_IDX   = 4'h1;
  localparam logic [3:0] STAT_IDX   = 4'h2;
  // control field positions
  localparam int CLK_SEL_LSB  = 0;
  localparam int START_BIT    = 3;
  localparam int MODE_LSB     = 4;
  localparam int ABORT_BIT    = 6;
  // status field positions
  localparam int ACTIVE_BIT   = 3;
  localparam int SHIFT_BIT    = 2;
  localparam int FULL_BIT     = 1;
  localparam int EMPTY_BIT    = 0;
  localparam logic [2:0] CLK_EXTERNAL = 3'h7;
  localparam logic [7:0] CTRL_RESET   = 8'h07;
  // internal half-period dividers, in clk cycles, for clock select 0..6
  // four at least: the input sync takes three cycles to show a new bit
  localparam int HALF_BASE    = 4;
  localparam int BITS_PER_BYTE = 8;
  typedef enum logic [1:0] {MODE_TX, MODE_RX, MODE_TXRX, MODE_RSVD} css_mode_t;
  typedef struct packed {
    logic       abort;
    css_mode_t  mode;
    logic       start;
    logic [2:0] clk_sel;
  } css_ctrl_t;
endpackage

// File: verification/css_serial_monitor.sv
module css_mon (
  // bus
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe_n,
  input wire logic        serial_out_pin,
  input wire logic        serial_buffer_irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire rq = avs_read | avs_write;
  property p_ack; $rose(rq) |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_ack1; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack1: assert property (p_ack1) else $error("long ack");
  property p_rd; $changed(avs_readdata) |-> avs_read && !avs_waitrequest; endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  property p_unm; avs_read && !avs_waitrequest && avs_address > 4'h2 |-> avs_readdata == 0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_irq; serial_buffer_irq |=> !serial_buffer_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq width");
  property p_out; $changed(serial_out_pin) && !serial_clock_pin_oe_n |-> !serial_clock_pin_out; endproperty
  a_out: assert property (p_out) else $error("out edge");
  // with the default divider no phase is shorter than two cycles
  property p_lo; $fell(serial_clock_pin_out) |=> !serial_clock_pin_out; endproperty
  a_lo: assert property (p_lo) else $error("low phase");
  property p_hi; $rose(serial_clock_pin_out) |=> serial_clock_pin_out; endproperty
  a_hi: assert property (p_hi) else $error("high phase");
  property p_idle; serial_clock_pin_oe_n |-> serial_clock_pin_out; endproperty
  a_idle: assert property (p_idle) else $error("clock idle");
  c_irq: cover property (serial_buffer_irq);
  c_fall: cover property ($fell(serial_clock_pin_out));
  c_unm: cover property (avs_read && !avs_waitrequest && avs_address > 4'h2);
endmodule

bind css_serial css_mon css_mon_inst (.clk, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .serial_clock_pin_out, .serial_clock_pin_oe_n,
  .serial_out_pin, .serial_buffer_irq);

// File: verification/css_peer.sv
module css_peer (
  // link
  input wire logic       sck,
  input wire logic       sdo,
  input wire logic       sync,
  input wire logic [7:0] tx_byte,
  output logic           sdi,
  output logic [7:0]     rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] idx_r;
  initial sdi = 1'b1;
  always @(posedge sck or posedge sync)
  begin
    if (sync)
      idx_r <= 3'h0;
    else
    begin
      rx_byte <= {sdo, rx_byte[7:1]};
      idx_r   <= idx_r + 3'h1;
    end
  end
  // between frames the line holds the last bit sent until sync flips it to the inverse
  always @(negedge sck or posedge sync)
    sdi <= sync ? ~sdi : tx_byte[idx_r];
endmodule

// File: verification/css_serial_tb_top.sv
module css_serial_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_clock_pin_out;
  logic        serial_clock_pin_oe_n;
  logic        serial_in_pin;
  logic        serial_out_pin;
  logic        serial_buffer_irq;
  logic        ext = 1'b1;
  logic        sync = 1'b0;
  logic [7:0]  ptx = 8'h00;
  logic [7:0]  prx;
  logic [31:0] got;
  int          miscompares = 0;
  int          checks_done = 0;
  wire         serial_clock_pin_in = serial_clock_pin_oe_n ? ext : serial_clock_pin_out;
  always #50 clk = ~clk;
  css_serial css_serial_inst (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe_n, .serial_in_pin, .serial_out_pin, .serial_buffer_irq);
  css_peer css_peer_inst (.sck(serial_clock_pin_in), .sdo(serial_out_pin), .sync,
    .tx_byte(ptx), .sdi(serial_in_pin), .rx_byte(prx));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    got = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wirq;
    int n;
    n = 0;
    do @(posedge clk); while (serial_buffer_irq !== 1'b1 && ++n < 400);
    chk(32'(n < 400), 32'h1);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do bus(0, 4'h2, 0); while (got[3] !== 1'b0 && ++n < 100);
    chk({31'h0, got[3]}, 32'h0);
  endtask
  task automatic peer(input logic [7:0] b);
    ptx  <= b;
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    bus(0, 4'h0, 0); chk(got, 32'h07);
    bus(1, 4'h3, 32'hFF); bus(0, 4'h3, 0); chk(got, 32'h0);
    $display("test reset done");
    peer(8'h00); bus(1, 4'h1, 32'hA5); bus(1, 4'h0, 32'h08);
    wirq;
    bus(1, 4'h0, 32'h00); idle; chk({24'h0, prx}, 32'hA5);
    $display("test tx done");
    peer(8'h3C); bus(1, 4'h0, 32'h18); wirq;
    repeat (40) @(posedge clk);
    chk({31'h0, serial_clock_pin_out}, 32'h1);
    bus(1, 4'h0, 32'h10); idle; bus(0, 4'h1, 0); chk(got, 32'h3C);
    $display("test rx done");
    peer(8'hC3); bus(1, 4'h0, 32'h20); bus(1, 4'h1, 32'h5A); bus(1, 4'h0, 32'h28);
    wirq; chk({24'h0, prx}, 32'h5A);
    bus(0, 4'h1, 0); chk(got, 32'hC3);
    bus(1, 4'h0, 32'h68); bus(0, 4'h2, 0); chk({31'h0, got[3]}, 32'h0);
    $display("test txrx done");
    bus(1, 4'h0, 32'h07); bus(1, 4'h1, 32'h77); bus(1, 4'h0, 32'h17);
    bus(0, 4'h1, 0); chk(got, 32'h0);
    $display("test mode done");
    bus(1, 4'h0, 32'h07); bus(1, 4'h1, 32'h96); peer(8'h00);
    bus(1, 4'h0, 32'h0F); bus(1, 4'h0, 32'h07);
    repeat (8)
    begin
      ext <= 1'b0;
      repeat (4) @(posedge clk);
      ext <= 1'b1;
      repeat (4) @(posedge clk);
    end
    chk({24'h0, prx}, 32'h96); idle;
    $display("test external done");
    close_out;
  end
endmodule
